/* File: core/rsx_alu.sv */
// Combinational operation unit for the datapath
`timescale 1ns/100ps
`default_nettype none
module rsx_alu
  import rsx_pkg::*;
(
  input wire rsx_op_t op, // Operation code
  input wire logic [7:0] work, // Working register value
  input wire logic [7:0] operand, // File register or literal
  input wire logic carry_in, // Current carry flag
  output rsx_alu_out_t alu_out // Result, flags and update strobes
);

  // Minuend minus subtrahend minus borrow, with carry as inverted borrow
  function automatic logic [9:0] sub_flags(input logic [7:0] a, input logic [7:0] b,
                                           input logic borrow);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} - {1'b0, b} - {8'h00, borrow};
    low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, borrow};
    sub_flags = {~low[4], ~full[8], full[7:0]};
  endfunction : sub_flags

  always_comb begin
    logic [9:0] s;
    s = 10'h000;
    alu_out = '0;
    unique case (op)
      OP_ROTATE_RIGHT: begin
        alu_out.result = {carry_in, operand[7:1]};
        alu_out.flags.carry = operand[0];
        alu_out.wr_carry = 1'b1;
      end
      OP_LIT_MINUS_WORK, OP_REG_MINUS_WORK, OP_REG_MINUS_WORK_BORROW: begin
        s = sub_flags(operand, work,
                      (op == OP_REG_MINUS_WORK_BORROW) ? ~carry_in : 1'b0);
        alu_out.result = s[7:0];
        alu_out.flags.carry = s[8];
        alu_out.flags.half = s[9];
        alu_out.flags.zero = (s[7:0] == 8'h00);
        alu_out.wr_carry = 1'b1;
        alu_out.wr_half = 1'b1;
        alu_out.wr_zero = 1'b1;
      end
      OP_NIBBLE_EXCHANGE: begin
        alu_out.result = {operand[3:0], operand[7:4]};
      end
      OP_LIT_XOR, OP_REG_XOR: begin
        alu_out.result = work ^ operand;
        alu_out.flags.zero = ((work ^ operand) == 8'h00);
        alu_out.wr_zero = 1'b1;
      end
      default: begin
        alu_out.result = work;
      end
    endcase
  end

endmodule : rsx_alu
`default_nettype wire

/* File: core/rsx_core.sv */
// APB-controlled execution unit for rotate, subtract, xor, swap, direction load and sleep
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module rsx_core
  import rsx_pkg::*;
(
  input wire logic CLK, // Instruction clock
  input wire logic RESET, // Asynchronous reset, active high
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB access phase
  input wire logic PWRITE, // APB direction
  input wire logic [31:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error on unmapped address
  input wire logic WAKE, // Wake request, leaves sleep
  output logic [7:0] PORT_A_DIR, // Port A direction
  output logic [7:0] PORT_B_DIR, // Port B direction
  output logic [7:0] PORT_C_DIR, // Port C direction
  output logic OSC_RUN, // Oscillator enable, low in sleep
  output logic [7:0] FILE_WR_DATA, // File register write-back data
  output logic FILE_WR // File register write-back pulse
);

  logic [3:0] op_reg, op_next;
  logic dest_reg, dest_next;
  logic [7:0] operand_reg, operand_next;
  logic [7:0] work_reg, work_next;
  logic [7:0] file_in_reg, file_in_next;
  logic [7:0] file_res_reg, file_res_next;
  logic file_wr_reg, file_wr_next;
  rsx_flags_t flags_reg, flags_next;
  logic to_reg, to_next;
  logic pd_reg, pd_next;
  logic sleep_reg, sleep_next;
  logic [7:0] wdt_reg, wdt_next;
  logic [7:0] prescale_reg, prescale_next;
  logic [7:0] dir_a_reg, dir_a_next;
  logic [7:0] dir_b_reg, dir_b_next;
  logic [7:0] dir_c_reg, dir_c_next;
  logic [31:0] rdata_reg, rdata_next;
  logic slverr_reg, slverr_next;
  logic wake_meta_reg, wake_sync_reg;

  logic access;
  logic write_hit;
  logic go;
  logic mapped;
  rsx_op_t cur_op;
  logic [7:0] alu_operand;
  logic reg_operand;
  rsx_alu_out_t alu_out;

  assign access = PSEL & PENABLE;
  assign write_hit = access & PWRITE;
  assign mapped = (PADDR == REG_CTRL) || (PADDR == REG_OPERAND) || (PADDR == REG_WORK) ||
                  (PADDR == REG_FILE_RESULT) || (PADDR == REG_STATUS) ||
                  (PADDR == REG_DIRECTION) || (PADDR == REG_WATCHDOG) ||
                  (PADDR == REG_FILE_IN);
  assign go = write_hit && (PADDR == REG_CTRL) && PWDATA[CTRL_GO_BIT] && !sleep_reg;
  assign cur_op = rsx_op_t'(PWDATA[CTRL_OP_LSB +: 4]);
  assign reg_operand = (cur_op == OP_ROTATE_RIGHT) || (cur_op == OP_REG_MINUS_WORK) ||
                       (cur_op == OP_REG_MINUS_WORK_BORROW) ||
                       (cur_op == OP_NIBBLE_EXCHANGE) || (cur_op == OP_REG_XOR);
  assign alu_operand = reg_operand ? file_in_reg : operand_reg;

  rsx_alu u_alu (
    .op(cur_op),
    .work(work_reg),
    .operand(alu_operand),
    .carry_in(flags_reg.carry),
    .alu_out(alu_out)
  );

  // Wake is asynchronous to the core clock
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      wake_meta_reg <= 1'b0;
      wake_sync_reg <= 1'b0;
    end else begin
      wake_meta_reg <= WAKE;
      wake_sync_reg <= wake_meta_reg;
    end
  end

  always_comb begin
    op_next = op_reg;
    dest_next = dest_reg;
    operand_next = operand_reg;
    work_next = work_reg;
    file_in_next = file_in_reg;
    file_res_next = file_res_reg;
    file_wr_next = 1'b0;
    flags_next = flags_reg;
    to_next = to_reg;
    pd_next = pd_reg;
    sleep_next = sleep_reg;
    wdt_next = wdt_reg + 8'h01;
    prescale_next = prescale_reg;
    dir_a_next = dir_a_reg;
    dir_b_next = dir_b_reg;
    dir_c_next = dir_c_reg;
    if (sleep_reg) begin
      wdt_next = wdt_reg;
    end
    if (wake_sync_reg && sleep_reg) begin
      sleep_next = 1'b0;
    end
    if (write_hit && !sleep_reg) begin
      unique case (PADDR)
        REG_OPERAND: operand_next = PWDATA[7:0];
        REG_WORK: work_next = PWDATA[7:0];
        REG_FILE_IN: file_in_next = PWDATA[7:0];
        REG_WATCHDOG: prescale_next = PWDATA[7:0];
        default: begin
        end
      endcase
    end
    if (go) begin
      op_next = PWDATA[CTRL_OP_LSB +: 4];
      dest_next = PWDATA[CTRL_DEST_BIT];
      if (alu_out.wr_carry) flags_next.carry = alu_out.flags.carry;
      if (alu_out.wr_half) flags_next.half = alu_out.flags.half;
      if (alu_out.wr_zero) flags_next.zero = alu_out.flags.zero;
      unique case (cur_op)
        OP_LIT_MINUS_WORK, OP_LIT_XOR: begin
          work_next = alu_out.result;
        end
        OP_ROTATE_RIGHT, OP_REG_MINUS_WORK, OP_REG_MINUS_WORK_BORROW,
        OP_NIBBLE_EXCHANGE, OP_REG_XOR: begin
          if (PWDATA[CTRL_DEST_BIT] == DEST_WORK) begin
            work_next = alu_out.result;
          end else begin
            file_res_next = alu_out.result;
            file_wr_next = 1'b1;
          end
        end
        OP_DIRECTION_LOAD: begin
          if (operand_reg == SEL_PORT_A) dir_a_next = work_reg;
          if (operand_reg == SEL_PORT_B) dir_b_next = work_reg;
          if (operand_reg == SEL_PORT_C) dir_c_next = work_reg;
        end
        OP_SLEEP: begin
          wdt_next = WDT_CLEAR;
          prescale_next = PRESCALE_CLEAR;
          to_next = 1'b1;
          pd_next = 1'b0;
          sleep_next = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    slverr_next = 1'b0;
    if (PSEL && !PENABLE) begin
      slverr_next = !mapped;
    end else if (access) begin
      slverr_next = slverr_reg;
    end
    if (PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR)
        REG_CTRL: rdata_next = {27'h0, dest_reg, op_reg};
        REG_OPERAND: rdata_next = {24'h0, operand_reg};
        REG_WORK: rdata_next = {24'h0, work_reg};
        REG_FILE_RESULT: rdata_next = {24'h0, file_res_reg};
        REG_STATUS: rdata_next = {26'h0, sleep_reg, to_reg, pd_reg, flags_reg.zero,
                                  flags_reg.half, flags_reg.carry};
        REG_DIRECTION: rdata_next = {8'h00, dir_c_reg, dir_b_reg, dir_a_reg};
        REG_WATCHDOG: rdata_next = {16'h0, prescale_reg, wdt_reg};
        REG_FILE_IN: rdata_next = {24'h0, file_in_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end else if (access) begin
      rdata_next = rdata_reg;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      op_reg <= 4'h0;
      dest_reg <= DEST_WORK;
      operand_reg <= 8'h00;
      work_reg <= WORK_RESET;
      file_in_reg <= 8'h00;
      file_res_reg <= 8'h00;
      file_wr_reg <= 1'b0;
      flags_reg <= '0;
      to_reg <= 1'b1;
      pd_reg <= 1'b1;
      sleep_reg <= 1'b0;
      wdt_reg <= WDT_CLEAR;
      prescale_reg <= PRESCALE_CLEAR;
      dir_a_reg <= DIR_RESET;
      dir_b_reg <= DIR_RESET;
      dir_c_reg <= DIR_RESET;
      rdata_reg <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end else begin
      op_reg <= op_next;
      dest_reg <= dest_next;
      operand_reg <= operand_next;
      work_reg <= work_next;
      file_in_reg <= file_in_next;
      file_res_reg <= file_res_next;
      file_wr_reg <= file_wr_next;
      flags_reg <= flags_next;
      to_reg <= to_next;
      pd_reg <= pd_next;
      sleep_reg <= sleep_next;
      wdt_reg <= wdt_next;
      prescale_reg <= prescale_next;
      dir_a_reg <= dir_a_next;
      dir_b_reg <= dir_b_next;
      dir_c_reg <= dir_c_next;
      rdata_reg <= rdata_next;
      slverr_reg <= slverr_next;
    end
  end

  assign PREADY = 1'b1;
  assign PRDATA = rdata_reg;
  assign PSLVERR = access && slverr_reg;
  assign PORT_A_DIR = dir_a_reg;
  assign PORT_B_DIR = dir_b_reg;
  assign PORT_C_DIR = dir_c_reg;
  assign OSC_RUN = ~sleep_reg;
  assign FILE_WR_DATA = file_res_reg;
  assign FILE_WR = file_wr_reg;

endmodule : rsx_core
`default_nettype wire

/* File: core/rsx_pkg.sv */
// Package for the rotate, subtract, exclusive-or and sleep datapath
package rsx_pkg;

  localparam logic [31:0] REG_CTRL = 32'h0000_0000;
  localparam logic [31:0] REG_OPERAND = 32'h0000_0004;
  localparam logic [31:0] REG_WORK = 32'h0000_0008;
  localparam logic [31:0] REG_FILE_RESULT = 32'h0000_000C;
  localparam logic [31:0] REG_STATUS = 32'h0000_0010;
  localparam logic [31:0] REG_DIRECTION = 32'h0000_0014;
  localparam logic [31:0] REG_WATCHDOG = 32'h0000_0018;
  localparam logic [31:0] REG_FILE_IN = 32'h0000_001C;

  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_DEST_BIT = 4;
  localparam int CTRL_GO_BIT = 8;
  localparam int ST_CARRY_BIT = 0;
  localparam int ST_HALF_BIT = 1;
  localparam int ST_ZERO_BIT = 2;
  localparam int ST_PD_BIT = 3;
  localparam int ST_TO_BIT = 4;
  localparam int ST_SLEEP_BIT = 5;

  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [7:0] WDT_CLEAR = 8'h00;
  localparam logic [7:0] PRESCALE_CLEAR = 8'h00;
  localparam logic [7:0] SEL_PORT_A = 8'h05;
  localparam logic [7:0] SEL_PORT_B = 8'h06;
  localparam logic [7:0] SEL_PORT_C = 8'h07;
  localparam logic DEST_WORK = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  typedef enum logic [3:0] {
    OP_ROTATE_RIGHT = 4'h0,
    OP_LIT_MINUS_WORK = 4'h1,
    OP_REG_MINUS_WORK = 4'h2,
    OP_REG_MINUS_WORK_BORROW = 4'h3,
    OP_NIBBLE_EXCHANGE = 4'h4,
    OP_DIRECTION_LOAD = 4'h5,
    OP_LIT_XOR = 4'h6,
    OP_REG_XOR = 4'h7,
    OP_SLEEP = 4'h8
  } rsx_op_t;

  typedef struct packed {
    logic carry;
    logic half;
    logic zero;
  } rsx_flags_t;

  typedef struct packed {
    logic [7:0] result;
    rsx_flags_t flags;
    logic wr_carry;
    logic wr_half;
    logic wr_zero;
  } rsx_alu_out_t;

endpackage : rsx_pkg

/* File: verification/rsx_core_assertions.sv */
// Port checks for the rotate, subtract, xor and sleep datapath
`timescale 1ns/100ps
`default_nettype none
module rsx_core_assertions
  import rsx_pkg::*;
(
  input wire logic CLK, // Clock
  input wire logic RESET, // Reset
  input wire logic PSEL, // Select
  input wire logic PENABLE, // Access
  input wire logic PWRITE, // Direction
  input wire logic [31:0] PADDR, // Address
  input wire logic [31:0] PWDATA, // Write data
  input wire logic WAKE, // Wake
  input wire logic [7:0] PORT_A_DIR, // Port A dir
  input wire logic [7:0] PORT_B_DIR, // Port B dir
  input wire logic [7:0] PORT_C_DIR, // Port C dir
  input wire logic OSC_RUN, // Oscillator
  input wire logic [7:0] FILE_WR_DATA, // Write-back data
  input wire logic FILE_WR // Write-back pulse
);
  logic wr, go, dst, reg_op;
  logic [3:0] op;
  logic [7:0] file_reg, file_next;
  assign wr = PSEL && PENABLE && PWRITE && OSC_RUN;
  assign go = wr && PADDR == REG_CTRL && PWDATA[CTRL_GO_BIT];
  assign dst = PWDATA[CTRL_DEST_BIT];
  assign op = PWDATA[3:0];
  assign reg_op = op inside {4'h0, 4'h2, 4'h3, 4'h4, 4'h7};
  // Last file operand written, for the swap check
  always_comb begin
    file_next = file_reg;
    if (wr && PADDR == REG_FILE_IN) begin
      file_next = PWDATA[7:0];
    end
  end
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      file_reg <= 8'h00;
    end else begin
      file_reg <= file_next;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  sleep_stops_osc_a: assert property (go && op == 4'h8 |=> !OSC_RUN)
    else $error("oscillator runs after sleep");
  sleep_holds_a: assert property ((!WAKE)[*4] ##0 !OSC_RUN |=> !OSC_RUN)
    else $error("sleep left without wake");
  dir_hold_a: assert property (!(go && op == 4'h5)
    |=> $stable({PORT_A_DIR, PORT_B_DIR, PORT_C_DIR}))
    else $error("direction changed without load");
  dest_file_a: assert property (go && reg_op && dst |=> FILE_WR)
    else $error("no write-back for file destination");
  dest_work_a: assert property (go && !dst |=> !FILE_WR)
    else $error("write-back for work destination");
  wr_pulse_a: assert property (FILE_WR |=> !FILE_WR)
    else $error("write-back pulse too long");
  wr_cause_a: assert property (FILE_WR |-> $past(go && reg_op && dst))
    else $error("write-back without cause");
  swap_data_a: assert property (go && op == 4'h4 && dst
    |=> FILE_WR_DATA == {file_reg[3:0], file_reg[7:4]})
    else $error("nibble exchange data wrong");
endmodule : rsx_core_assertions
bind rsx_core rsx_core_assertions chk_u (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .WAKE(WAKE),
  .PORT_A_DIR(PORT_A_DIR), .PORT_B_DIR(PORT_B_DIR), .PORT_C_DIR(PORT_C_DIR),
  .OSC_RUN(OSC_RUN), .FILE_WR_DATA(FILE_WR_DATA), .FILE_WR(FILE_WR));
`default_nettype wire

/* File: verification/rsx_core_tb.sv */
// Self-checking testbench for the rotate, subtract, xor and sleep datapath
`timescale 1ns/100ps
`default_nettype none
module rsx_core_tb
  import rsx_pkg::*;
;
  logic CLK, RESET, PSEL, PENABLE, PWRITE, WAKE, PREADY, PSLVERR, OSC_RUN, FILE_WR;
  logic [31:0] PADDR, PWDATA, PRDATA;
  logic [7:0] PORT_A_DIR, PORT_B_DIR, PORT_C_DIR, FILE_WR_DATA;
  int bad_count = 0;
  int samples_checked = 0;
  logic [32:0] rd_q[$];
  logic [7:0] fw_q[$];
  logic [7:0] w, fr, k, r;
  logic [7:0] seed = 8'h48;
  logic c, dc, z;
  logic pd = 1'b1;
  logic to = 1'b1;
  logic sl = 1'b0;
  logic [23:0] dirs = {DIR_RESET, DIR_RESET, DIR_RESET};

  rsx_core dut_u (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .WAKE(WAKE), .PORT_A_DIR(PORT_A_DIR), .PORT_B_DIR(PORT_B_DIR),
    .PORT_C_DIR(PORT_C_DIR), .OSC_RUN(OSC_RUN), .FILE_WR_DATA(FILE_WR_DATA),
    .FILE_WR(FILE_WR));

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  function automatic logic [7:0] rnd();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction : rnd

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic rd(input logic [31:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic chk_rd(input logic [32:0] e, input logic [32:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR read exp %h got %h", e, g);
    end
  endtask : chk_rd

  task automatic chk_fw(input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR write-back exp %h got %h", e, g);
    end
  endtask : chk_fw

  task automatic chk_out(input logic [24:0] e, input logic [24:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR pins exp %h got %h", e, g);
    end
  endtask : chk_out

  task automatic chk_state();
    rd(REG_WORK, {25'h0, w});
    rd(REG_STATUS, {27'h0, sl, to, pd, z, dc, c});
    rd(REG_DIRECTION, {9'h0, dirs});
    chk_out({~sl, dirs}, {OSC_RUN, PORT_C_DIR, PORT_B_DIR, PORT_A_DIR});
  endtask : chk_state

  // Reference model of one operation, then launch it
  task automatic run(input logic [3:0] op, input logic d);
    logic [7:0] a, res;
    logic [8:0] t;
    logic [4:0] h;
    logic cin;
    apb(1'b1, REG_WORK, {24'h0, w});
    apb(1'b1, REG_FILE_IN, {24'h0, fr});
    apb(1'b1, REG_OPERAND, {24'h0, k});
    a = (op == 4'h1) ? k : fr;
    cin = (op == 4'h3) ? c : 1'b1;
    t = {1'b0, a} + {1'b0, ~w} + {8'h0, cin};
    h = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + {4'h0, cin};
    res = w;
    case (op)
      4'h0: begin
        res = {c, fr[7:1]};
        c = fr[0];
      end
      4'h1, 4'h2, 4'h3: begin
        res = t[7:0];
        c = t[8];
        dc = h[4];
      end
      4'h4: res = {fr[3:0], fr[7:4]};
      4'h5: begin
        if (k == SEL_PORT_A) dirs[7:0] = w;
        if (k == SEL_PORT_B) dirs[15:8] = w;
        if (k == SEL_PORT_C) dirs[23:16] = w;
      end
      4'h6: res = w ^ k;
      default: res = w ^ fr;
    endcase
    if (op inside {4'h1, 4'h2, 4'h3, 4'h6, 4'h7}) z = (res == 8'h00);
    if (d && op inside {4'h0, 4'h2, 4'h3, 4'h4, 4'h7}) fw_q.push_back(res);
    else if (op != 4'h5) w = res;
    apb(1'b1, REG_CTRL, {23'h0, 1'b1, 3'h0, d, op});
    chk_state();
  endtask : run

  task automatic end_sim();
    bad_count += rd_q.size() + fw_q.size();
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  always @(posedge CLK) begin
    if (!RESET && PSEL && PENABLE && !PWRITE && PREADY)
      chk_rd(rd_q.size() ? rd_q.pop_front() : 'x, {PSLVERR, PRDATA});
    if (!RESET && FILE_WR === 1'b1)
      chk_fw(fw_q.size() ? fw_q.pop_front() : 'x, FILE_WR_DATA);
  end

  initial begin
    repeat (20000) @(posedge CLK);
    bad_count++;
    end_sim();
  end

  initial begin
    RESET = 1'b1;
    {PSEL, PENABLE, PWRITE, WAKE} = 4'h0;
    PADDR = 32'h0;
    PWDATA = 32'h0;
    repeat (10) @(posedge CLK);
    RESET <= 1'b0;
    rd(REG_DIRECTION, {9'h0, dirs});
    rd(REG_WORK, {25'h0, WORK_RESET});
    rd(32'h0000_0020, {1'b1, 32'h0});
    {w, fr, k} = 24'h0;
    run(4'h1, 1'b0);
    for (int i = 0; i < 200; i++) begin
      w = rnd();
      fr = rnd();
      k = rnd();
      r = rnd();
      if (r[7:6] == 2'h0) begin
        k = w;
        fr = w;
      end
      if (i < 16) r[3:0] = i[3:0];
      if (r[2:0] == 3'h5) k = {6'h0, k[1:0]} + 8'h05;
      run({1'b0, r[2:0]}, r[3]);
    end
    apb(1'b1, REG_WATCHDOG, 32'h0000_005A);
    apb(1'b1, REG_CTRL, 32'h0000_0108);
    pd = 1'b0;
    sl = 1'b1;
    apb(1'b1, REG_WORK, 32'h0000_003C);
    apb(1'b1, REG_CTRL, 32'h0000_0106);
    chk_state();
    rd(REG_WATCHDOG, {1'b0, 32'h0});
    WAKE <= 1'b1;
    for (int n = 0; n < 20 && OSC_RUN !== 1'b1; n++) @(posedge CLK);
    WAKE <= 1'b0;
    sl = 1'b0;
    chk_state();
    w = rnd();
    fr = rnd();
    run(4'h7, 1'b1);
    repeat (4) @(posedge CLK);
    end_sim();
  end
endmodule : rsx_core_tb
`default_nettype wire
